// File: logic/run_cmd_params.svh
// Constants for the run command source selector
// Operation
// R1: Run commands come only from the selected source 0..5.
// R2: Keypad: forward key runs forward, reverse key runs reverse, stop key stops.
// R3: Scheme one: forward input runs forward, reverse input runs reverse.
// R4: Scheme one: both inputs on or both off means stop.
// R5: Scheme two: forward input is run, reverse input picks direction.
// R6: Terminal schemes wait a programmable run-on delay, 0 to 100 s, default 1 s.
// R7: Any of 11 inputs acts as forward or reverse by function code 1 or 2.
// R8: Serial source takes run commands only from the RS-485 link.
// R9: Holds station id 1..250 default 1, protocol default Modbus RTU, baud default 9600.
// R10: Selector writes outside 0..5 are ignored, old source kept. Code checks only bits 2:0, so a write of 8 selects source 0.
`ifndef RUN_CMD_PARAMS_SVH
`define RUN_CMD_PARAMS_SVH
`define ADDR_SOURCE 8'h00
`define ADDR_DELAY 8'h04
`define ADDR_FUNC_LO 8'h08
`define ADDR_FUNC_HI 8'h0C
`define ADDR_FUNC_TOP 8'h10
`define ADDR_SERIAL 8'h14
`define ADDR_STATUS 8'h18
`define ADDR_INPUTS 8'h1C
`define SOURCE_RESET 3'h1
`define SOURCE_MAX 3'h5
`define DELAY_RESET 14'h0064
`define DELAY_MAX 14'h2710
`define FUNC_MAX 6'h33
`define FUNC_FORWARD 6'h01
`define FUNC_REVERSE 6'h02
`define STATION_RESET 8'h01
`define STATION_MIN 8'h01
`define STATION_MAX 8'hFA
`define PROTO_RESET 4'h0
`define BAUD_RESET 4'h3
`define BAUD_MAX 4'h5
`define CLOCK_HZ 125000000
`define DELAY_UNIT_MS 10
`define CYCLES_PER_UNIT (`CLOCK_HZ / 1000 * `DELAY_UNIT_MS)
`endif

// File: logic/run_cmd_pkg.sv
// Types for the run command source selector
package run_cmd_pkg;
    typedef enum logic [2:0] {
        SRC_KEYPAD = 3'b000,
        SRC_SCHEME_ONE = 3'b001,
        SRC_SCHEME_TWO = 3'b010,
        SRC_SERIAL = 3'b011,
        SRC_FIELD_BUS = 3'b100,
        SRC_PLC = 3'b101
    } source_t;
    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_WAIT = 2'b01,
        RUN_ON = 2'b10
    } run_state_t;
endpackage

// File: logic/run_on_delay.sv
// Run-on delay timer for terminal commands
`timescale 1ns/1ps
`include "run_cmd_params.svh"
module run_on_delay #(
    parameter int unsigned CYCLES_PER_UNIT = `CYCLES_PER_UNIT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic request,
    input wire logic [13:0] delay_units,
    output logic expired
);
    logic [31:0] cycle_reg, cycle_next;
    logic [13:0] unit_reg, unit_next;
    logic expired_reg, expired_next;

    always_comb begin
        cycle_next = cycle_reg;
        unit_next = unit_reg;
        expired_next = expired_reg;
        if (!request) begin
            cycle_next = '0;
            unit_next = '0;
            expired_next = 1'b0;
        end else if (!expired_reg) begin
            if (unit_reg >= delay_units) begin
                expired_next = 1'b1; // see R6
            end else if (cycle_reg >= CYCLES_PER_UNIT - 1) begin
                cycle_next = '0;
                unit_next = unit_reg + 14'h0001;
            end else begin
                cycle_next = cycle_reg + 32'h00000001;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cycle_reg <= '0;
            unit_reg <= '0;
            expired_reg <= 1'b0;
        end else begin
            cycle_reg <= cycle_next;
            unit_reg <= unit_next;
            expired_reg <= expired_next;
        end
    end

    assign expired = expired_reg;
endmodule

// File: logic/run_command_source_selector.sv
// Run command source selector with AXI4-Lite register access
`timescale 1ns/1ps
`include "run_cmd_params.svh"
module run_command_source_selector #(
    parameter int unsigned NUM_TERMINALS = 11,
    parameter int unsigned CYCLES_PER_UNIT = `CYCLES_PER_UNIT
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [7:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic key_forward,
    input wire logic key_reverse,
    input wire logic key_stop,
    input wire logic [NUM_TERMINALS-1:0] terminal_inputs,
    input wire logic serial_run,
    input wire logic serial_reverse,
    input wire logic serial_stop,
    input wire logic field_bus_run,
    input wire logic field_bus_reverse,
    input wire logic plc_run,
    input wire logic plc_reverse,
    output logic run_active,
    output logic run_reverse,
    output run_cmd_pkg::source_t source_active
);
    import run_cmd_pkg::*;

    // Key and terminal pins cross two flops before use
    logic [NUM_TERMINALS+2:0] pin_meta_reg, pin_sync_reg;
    logic [NUM_TERMINALS-1:0] term_sync;
    logic key_fwd_s, key_rev_s, key_stop_s;

    source_t source_reg, source_next;
    logic [13:0] delay_reg, delay_next;
    logic [5:0] func_reg [NUM_TERMINALS], func_next [NUM_TERMINALS];
    logic [7:0] station_reg, station_next;
    logic [3:0] proto_reg, proto_next, baud_reg, baud_next;

    logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    run_state_t state_reg, state_next;
    logic run_reg, run_next, rev_reg, rev_next;
    logic want_run, want_rev, term_mode, delay_done, fwd_in, rev_in;

    function automatic logic [5:0] merge6(input logic [5:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input int unsigned lsb);
        logic [5:0] v;
        v = old;
        if (strb[lsb / 8] && data[lsb +: 6] <= `FUNC_MAX) begin
            v = data[lsb +: 6];
        end
        return v;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= {key_stop, key_reverse, key_forward, terminal_inputs};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    assign {key_stop_s, key_rev_s, key_fwd_s, term_sync} = pin_sync_reg;

    // Any terminal with code 1 or 2 acts as forward or reverse
    always_comb begin
        fwd_in = 1'b0;
        rev_in = 1'b0;
        for (int i = 0; i < NUM_TERMINALS; i++) begin
            fwd_in |= (func_reg[i] == `FUNC_FORWARD && term_sync[i]); // see R7
            rev_in |= (func_reg[i] == `FUNC_REVERSE && term_sync[i]); // see R7
        end
    end

    // Register bus
    logic do_write, do_read;
    assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign do_read = s_axil_arvalid && !rvalid_reg;
    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        source_next = source_reg;
        delay_next = delay_reg;
        func_next = func_reg;
        station_next = station_reg;
        proto_next = proto_reg;
        baud_next = baud_reg;
        if (s_axil_awvalid && !aw_hold_reg) begin
            aw_hold_next = 1'b1;
            aw_addr_next = s_axil_awaddr;
        end
        if (s_axil_wvalid && !w_hold_reg) begin
            w_hold_next = 1'b1;
            w_data_next = s_axil_wdata;
            w_strb_next = s_axil_wstrb;
        end
        if (do_write) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = 2'b00;
            case (aw_addr_reg & 8'hFC)
                `ADDR_SOURCE: begin
                    if (w_strb_reg[0] && w_data_reg[2:0] <= `SOURCE_MAX) begin
                        source_next = source_t'(w_data_reg[2:0]); // see R1, R10
                    end
                end
                `ADDR_DELAY: begin
                    if (w_strb_reg[1:0] == 2'b11 && w_data_reg[13:0] <= `DELAY_MAX) begin
                        delay_next = w_data_reg[13:0]; // see R6
                    end
                end
                `ADDR_FUNC_LO, `ADDR_FUNC_HI, `ADDR_FUNC_TOP: begin
                    for (int i = 0; i < NUM_TERMINALS; i++) begin
                        if (i / 4 == int'((aw_addr_reg - `ADDR_FUNC_LO) >> 2)) begin
                            func_next[i] = merge6(func_reg[i], w_data_reg, w_strb_reg, (i % 4) * 8); // see R7
                        end
                    end
                end
                `ADDR_SERIAL: begin
                    if (w_strb_reg[0] && w_data_reg[7:0] >= `STATION_MIN && w_data_reg[7:0] <= `STATION_MAX) begin
                        station_next = w_data_reg[7:0]; // see R9
                    end
                    if (w_strb_reg[1]) begin
                        proto_next = w_data_reg[11:8];
                    end
                    if (w_strb_reg[2] && w_data_reg[19:16] <= `BAUD_MAX) begin
                        baud_next = w_data_reg[19:16]; // see R9
                    end
                end
                default: bresp_next = 2'b10;
            endcase
        end
        if (bvalid_reg && s_axil_bready) begin
            bvalid_next = 1'b0;
        end
        if (rvalid_reg && s_axil_rready) begin
            rvalid_next = 1'b0;
        end
        if (do_read) begin
            rvalid_next = 1'b1;
            rresp_next = 2'b00;
            rdata_next = '0;
            case (s_axil_araddr & 8'hFC)
                `ADDR_SOURCE: rdata_next = {29'h0, source_reg};
                `ADDR_DELAY: rdata_next = {18'h0, delay_reg};
                `ADDR_FUNC_LO, `ADDR_FUNC_HI, `ADDR_FUNC_TOP: begin
                    for (int i = 0; i < NUM_TERMINALS; i++) begin
                        if (i / 4 == int'((s_axil_araddr - `ADDR_FUNC_LO) >> 2)) begin
                            rdata_next[(i % 4) * 8 +: 6] = func_reg[i];
                        end
                    end
                end
                `ADDR_SERIAL: rdata_next = {12'h0, baud_reg, 4'h0, proto_reg, station_reg};
                `ADDR_STATUS: rdata_next = {27'h0, state_reg, 1'b0, rev_reg, run_reg};
                `ADDR_INPUTS: rdata_next = {16'h0, rev_in, fwd_in, 3'h0, 11'(term_sync)};
                default: rresp_next = 2'b10;
            endcase
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= 2'b00;
            source_reg <= source_t'(`SOURCE_RESET);
            delay_reg <= `DELAY_RESET;
            func_reg <= '{default: 6'h00};
            station_reg <= `STATION_RESET;
            proto_reg <= `PROTO_RESET;
            baud_reg <= `BAUD_RESET;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            source_reg <= source_next;
            delay_reg <= delay_next;
            func_reg <= func_next;
            station_reg <= station_next;
            proto_reg <= proto_next;
            baud_reg <= baud_next;
        end
    end

    // Command decode per source
    always_comb begin
        want_run = 1'b0;
        want_rev = rev_reg;
        term_mode = 1'b0;
        case (source_reg)
            SRC_KEYPAD: begin
                // Keys latch; stop has priority over a start key
                want_run = run_reg;
                if (key_stop_s) begin
                    want_run = 1'b0; // see R2
                end else if (key_fwd_s) begin
                    want_run = 1'b1; // see R2
                    want_rev = 1'b0;
                end else if (key_rev_s) begin
                    want_run = 1'b1; // see R2
                    want_rev = 1'b1;
                end
            end
            SRC_SCHEME_ONE: begin
                term_mode = 1'b1;
                want_run = fwd_in ^ rev_in; // see R3, R4
                want_rev = rev_in && !fwd_in ? 1'b1 : (fwd_in && !rev_in ? 1'b0 : rev_reg);
            end
            SRC_SCHEME_TWO: begin
                term_mode = 1'b1;
                want_run = fwd_in; // see R5
                want_rev = rev_in; // see R5
            end
            SRC_SERIAL: begin
                want_run = (run_reg || serial_run) && !serial_stop; // see R8
                want_rev = serial_run ? serial_reverse : rev_reg;
            end
            SRC_FIELD_BUS: begin
                want_run = field_bus_run; // see R1
                want_rev = field_bus_reverse;
            end
            SRC_PLC: begin
                want_run = plc_run; // see R1
                want_rev = plc_reverse;
            end
            default: want_run = 1'b0;
        endcase
    end
    run_on_delay #(
        .CYCLES_PER_UNIT(CYCLES_PER_UNIT)
    ) u_delay (
        .aclk(aclk),
        .aresetn(aresetn),
        .request(term_mode && want_run && state_reg != RUN_ON),
        .delay_units(delay_reg),
        .expired(delay_done)
    );

    // Direction follows live; only the start is delayed
    always_comb begin
        state_next = state_reg;
        run_next = 1'b0;
        rev_next = want_rev;
        case (state_reg)
            RUN_IDLE: begin
                if (want_run) begin
                    state_next = term_mode ? RUN_WAIT : RUN_ON;
                    run_next = !term_mode;
                end else begin
                    rev_next = rev_reg;
                end
            end
            RUN_WAIT: begin
                if (!want_run || !term_mode) begin
                    state_next = RUN_IDLE;
                end else if (delay_done) begin
                    state_next = RUN_ON; // see R6
                    run_next = 1'b1;
                end
            end
            RUN_ON: begin
                run_next = want_run;
                if (!want_run) begin
                    state_next = RUN_IDLE;
                end
            end
            default: state_next = RUN_IDLE;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= RUN_IDLE;
            run_reg <= 1'b0;
            rev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            run_reg <= run_next;
            rev_reg <= rev_next;
        end
    end
    assign s_axil_awready = !aw_hold_reg;
    assign s_axil_wready = !w_hold_reg;
    assign s_axil_bvalid = bvalid_reg;
    assign s_axil_bresp = bresp_reg;
    assign s_axil_arready = !rvalid_reg;
    assign s_axil_rvalid = rvalid_reg;
    assign s_axil_rdata = rdata_reg;
    assign s_axil_rresp = rresp_reg;
    assign run_active = run_reg;
    assign run_reverse = rev_reg;
    assign source_active = source_reg;
endmodule

// File: verif/run_cmd_props.sv
// Bus and run output checks for the source selector
`timescale 1ns/1ps
module run_cmd_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic key_stop,
    input wire logic serial_stop,
    input wire logic field_bus_run,
    input wire logic field_bus_reverse,
    input wire logic run_active,
    input wire logic run_reverse,
    input wire run_cmd_pkg::source_t source_active
);
    import run_cmd_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_AW_HELD: assert property (s_axil_awvalid && s_axil_awready |=> !s_axil_awready)
        else $error("awready not dropped");
    AST_B_AFTER: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready
        |-> ##[1:2] s_axil_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
        else $error("bvalid dropped early");
    AST_R_AFTER: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read data late");
    AST_R_HOLD: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data not held");
    AST_AR_BLOCK: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("arready during read");
    AST_SRC_RANGE: assert property (source_active <= SRC_PLC)
        else $error("source out of range");
    AST_RESET_VALS: assert property ($rose(aresetn) |-> !run_active && !run_reverse
        && source_active == SRC_SCHEME_ONE)
        else $error("bad reset values");
    AST_KEY_STOP: assert property ((source_active == SRC_KEYPAD && key_stop) [*4] |=> !run_active)
        else $error("stop key did not stop");
    AST_FB_PASS: assert property ((source_active == SRC_FIELD_BUS && field_bus_run && field_bus_reverse) [*4]
        |=> run_active && run_reverse)
        else $error("field bus not followed");
    AST_SER_STOP: assert property ((source_active == SRC_SERIAL && serial_stop) [*4] |=> !run_active)
        else $error("serial stop did not stop");
endmodule
bind run_command_source_selector run_cmd_props props_i (.*);

// File: verif/cmd_source_model.sv
// Keypad, terminal contacts and upper controller levels
`timescale 1ns/1ps
module cmd_source_model (
    input wire logic aclk,
    output logic key_forward,
    output logic key_reverse,
    output logic key_stop,
    output logic [10:0] terminal_inputs,
    output logic serial_run,
    output logic serial_reverse,
    output logic serial_stop,
    output logic field_bus_run,
    output logic field_bus_reverse,
    output logic plc_run,
    output logic plc_reverse
);
    initial {key_forward, key_reverse, key_stop, terminal_inputs, serial_run, serial_reverse, serial_stop,
             field_bus_run, field_bus_reverse, plc_run, plc_reverse} = '0;
    task automatic set_keys(input logic f, input logic r, input logic s);
        @(posedge aclk);
        key_forward <= f;
        key_reverse <= r;
        key_stop <= s;
    endtask
    task automatic set_terms(input logic [10:0] v);
        @(posedge aclk);
        terminal_inputs <= v;
    endtask
    // Controller owns the link levels, always driven, never floating
    task automatic set_serial(input logic r, input logic d, input logic s);
        @(posedge aclk);
        serial_run <= r;
        serial_reverse <= d;
        serial_stop <= s;
    endtask
    task automatic set_aux(input logic v);
        @(posedge aclk);
        field_bus_run <= v;
        field_bus_reverse <= v;
        plc_run <= v;
        plc_reverse <= v;
    endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the run command source selector
`timescale 1ns/1ps
`include "run_cmd_params.svh"
module tb_top;
    import run_cmd_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axil_awaddr = 8'h00;
    logic [7:0] s_axil_araddr = 8'h00;
    logic [31:0] s_axil_wdata = 32'h00000000;
    logic [3:0] s_axil_wstrb = 4'hF;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp, rsp;
    logic [31:0] s_axil_rdata, rd;
    logic key_forward, key_reverse, key_stop, serial_run, serial_reverse, serial_stop;
    logic field_bus_run, field_bus_reverse, plc_run, plc_reverse, run_active, run_reverse;
    logic [10:0] terminal_inputs;
    source_t source_active;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    // Short unit keeps the run-on delay to a few cycles
    run_command_source_selector #(.NUM_TERMINALS(11), .CYCLES_PER_UNIT(4)) uut (.*);
    cmd_source_model far_side (.*);
    initial begin
        forever #4 aclk = ~aclk;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        // Whole run needs a few hundred cycles
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            bad_count++;
        end
    endtask
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        bit done;
        done = 0;
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axil_awvalid && s_axil_awready) s_axil_awvalid <= 1'b0;
            if (s_axil_wvalid && s_axil_wready) s_axil_wvalid <= 1'b0;
            if (s_axil_bvalid) begin
                rsp = s_axil_bresp;
                s_axil_bready <= 1'b0;
                done = 1;
            end
        end
    endtask
    task automatic axi_read(input logic [7:0] a);
        bit done;
        done = 0;
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axil_arvalid && s_axil_arready) s_axil_arvalid <= 1'b0;
            if (s_axil_rvalid) begin
                rd = s_axil_rdata;
                rsp = s_axil_rresp;
                s_axil_rready <= 1'b0;
                done = 1;
            end
        end
    endtask
    task automatic wait_run(input logic er, input logic ed, input int lim);
        int i;
        i = 0;
        while (run_active !== er && i < lim) begin
            @(posedge aclk);
            i++;
        end
        check("run_active", run_active, er);
        if (er) check("run_reverse", run_reverse, ed);
    endtask
    task automatic press(input logic f, input logic r, input logic s);
        far_side.set_keys(f, r, s);
        repeat (5) @(posedge aclk);
        far_side.set_keys(1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_reset();
        axi_read(`ADDR_SOURCE);
        check("source", rd, 32'h00000001);
        axi_read(`ADDR_DELAY);
        check("delay", rd, 32'h00000064);
        axi_read(`ADDR_SERIAL);
        check("serial", rd, 32'h00030001);
        axi_read(`ADDR_FUNC_LO);
        check("func", rd, 32'h00000000);
    endtask
    task automatic t_select();
        axi_write(`ADDR_SOURCE, 32'h00000006);
        check("bresp", rsp, 2'b00);
        axi_write(`ADDR_SOURCE, 32'h00000007);
        axi_read(`ADDR_SOURCE);
        check("source", rd, 32'h00000001);
        check("source_active", source_active, SRC_SCHEME_ONE);
        axi_write(8'h20, 32'h00000001);
        check("bresp", rsp, 2'b10);
        axi_write(`ADDR_STATUS, 32'h00000001);
        check("bresp", rsp, 2'b10);
        axi_read(8'h20);
        check("rresp", rsp, 2'b10);
        for (int i = 0; i < 6; i++) begin
            axi_write(`ADDR_SOURCE, i);
            repeat (2) @(posedge aclk);
            check("source_active", source_active, i);
        end
    endtask
    task automatic t_keypad();
        axi_write(`ADDR_SOURCE, 32'h00000000);
        far_side.set_aux(1'b1);
        repeat (8) @(posedge aclk);
        wait_run(1'b0, 1'b0, 0);
        far_side.set_aux(1'b0);
        press(1'b1, 1'b0, 1'b0);
        repeat (10) @(posedge aclk);
        wait_run(1'b1, 1'b0, 0);
        press(1'b0, 1'b0, 1'b1);
        wait_run(1'b0, 1'b0, 10);
        press(1'b0, 1'b1, 1'b0);
        wait_run(1'b1, 1'b1, 10);
        press(1'b0, 1'b0, 1'b1);
        wait_run(1'b0, 1'b0, 10);
        press(1'b1, 1'b0, 1'b1);
        repeat (8) @(posedge aclk);
        wait_run(1'b0, 1'b0, 0);
    endtask
    task automatic t_scheme_one();
        logic [10:0] vec [4];
        logic [1:0] exp [4];
        vec = '{11'h004, 11'h204, 11'h200, 11'h000};
        exp = '{2'b10, 2'b00, 2'b11, 2'b00};
        axi_write(`ADDR_DELAY, 32'h00000000);
        axi_write(`ADDR_FUNC_LO, 32'h00010034);
        axi_read(`ADDR_FUNC_LO);
        check("func", rd, 32'h00010000);
        axi_write(`ADDR_FUNC_TOP, 32'h00000200);
        axi_write(`ADDR_SOURCE, 32'h00000001);
        for (int i = 0; i < 4; i++) begin
            far_side.set_terms(vec[i]);
            wait_run(exp[i][1], exp[i][0], 20);
        end
    endtask
    task automatic t_delay();
        axi_write(`ADDR_DELAY, 32'h00000005);
        axi_write(`ADDR_DELAY, 32'h00002711);
        s_axil_wstrb <= 4'h1;
        axi_write(`ADDR_DELAY, 32'h00000007);
        s_axil_wstrb <= 4'hF;
        axi_read(`ADDR_DELAY);
        check("delay", rd, 32'h00000005);
        axi_write(`ADDR_SOURCE, 32'h00000002);
        far_side.set_terms(11'h004);
        repeat (16) @(posedge aclk);
        wait_run(1'b0, 1'b0, 0);
        wait_run(1'b1, 1'b0, 30);
        far_side.set_terms(11'h204);
        repeat (6) @(posedge aclk);
        wait_run(1'b1, 1'b1, 0);
        axi_read(`ADDR_INPUTS);
        check("inputs", rd, 32'h0000C204);
        far_side.set_terms(11'h200);
        wait_run(1'b0, 1'b0, 10);
    endtask
    task automatic t_serial();
        axi_write(`ADDR_SOURCE, 32'h00000003);
        far_side.set_terms(11'h004);
        repeat (10) @(posedge aclk);
        wait_run(1'b0, 1'b0, 0);
        far_side.set_terms(11'h000);
        far_side.set_serial(1'b1, 1'b1, 1'b0);
        wait_run(1'b1, 1'b1, 10);
        far_side.set_serial(1'b0, 1'b1, 1'b0);
        repeat (5) @(posedge aclk);
        wait_run(1'b1, 1'b1, 0);
        axi_read(`ADDR_STATUS);
        check("status", rd, 32'h00000013);
        far_side.set_serial(1'b0, 1'b0, 1'b1);
        repeat (6) @(posedge aclk);
        wait_run(1'b0, 1'b0, 0);
        far_side.set_serial(1'b0, 1'b0, 1'b0);
        axi_write(`ADDR_SERIAL, 32'h000500FA);
        axi_write(`ADDR_SERIAL, 32'h000600FB);
        axi_read(`ADDR_SERIAL);
        check("serial", rd, 32'h000500FA);
        axi_write(`ADDR_SERIAL, 32'h00000000);
        axi_read(`ADDR_SERIAL);
        check("serial", rd, 32'h000000FA);
    endtask
    task automatic t_aux();
        for (int s = 4; s < 6; s++) begin
            axi_write(`ADDR_SOURCE, s);
            far_side.set_aux(1'b1);
            wait_run(1'b1, 1'b1, 10);
            repeat (6) @(posedge aclk);
            far_side.set_aux(1'b0);
            wait_run(1'b0, 1'b0, 10);
        end
    endtask
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_select();
        t_keypad();
        t_scheme_one();
        t_delay();
        t_serial();
        t_aux();
        give_verdict();
    end
endmodule
